// ==== design/smcg_pkg.sv ====
// Constants and carrier types for the standby and module clock gating block.
// Assumes an APB master on pclk and peripherals that take a gated clock each.
//
// How it works
// - Three 8-bit read/write standby registers; defined fields reset 0.
// - Primary bit 7 picks sleep (0) or deep standby (1) on halt.
// - Primary bit 4 keeps the crystal running in standby when set.
// - Primary bit 2 set stops the timer unit clock.
// - Primary bit 1 set stops the real-time unit clock.
// - Reserved bits read 0; software writes 0 there.
// - Second bit 7 set stops the debug interface clock.
// - Second bit 6 set stops the break controller clock.
// - Second bit 5 set stops the DMA controller clock.
// - Second bit 3 set stops the translation buffer clock.
// - Second bit 2 set stops the cache clock.
// - Third bit 7 set stops the USB clock.
// - Third bit 5 set stops the compare match timer clock.
// - Third bit 4 set stops the timer pulse unit clock.
// - Third bit 3 set stops the converter control clock.
// - Third bit 2 set stops the infrared interface clock.
// - Third bits 1 and 0 stop serial FIFO channels 2 and 0.
// - Clearing a stop bit or reset restores the clock; bit reads back.
// - State pins: reset HH, sleep HL, standby LH, normal LL.
package smcg_pkg;

   // Register byte offsets
   localparam logic [11:0] SMCG_OFS_PRIMARY = 12'h000;
   localparam logic [11:0] SMCG_OFS_SECOND = 12'h004;
   localparam logic [11:0] SMCG_OFS_THIRD = 12'h008;
   localparam logic [11:0] SMCG_OFS_STATUS = 12'h00c;

   // Reset values and writable masks
   localparam logic [7:0] SMCG_RST_REG = 8'h00;
   localparam logic [7:0] SMCG_WMASK_PRIMARY = 8'h96;
   localparam logic [7:0] SMCG_WMASK_SECOND = 8'hec;
   localparam logic [7:0] SMCG_WMASK_THIRD = 8'hbf;

   // Field positions, primary register
   localparam int SMCG_BIT_DEEP_STANDBY = 7;
   localparam int SMCG_BIT_CRYSTAL_KEEP = 4;
   localparam int SMCG_BIT_TIMER = 2;
   localparam int SMCG_BIT_REALTIME = 1;
   // Second register
   localparam int SMCG_BIT_DEBUG = 7;
   localparam int SMCG_BIT_BREAK = 6;
   localparam int SMCG_BIT_DMA = 5;
   localparam int SMCG_BIT_TLB = 3;
   localparam int SMCG_BIT_CACHE = 2;
   // Third register
   localparam int SMCG_BIT_USB = 7;
   localparam int SMCG_BIT_COMPARE_TIMER = 5;
   localparam int SMCG_BIT_PULSE_UNIT = 4;
   localparam int SMCG_BIT_ADC = 3;
   localparam int SMCG_BIT_IRDA = 2;
   localparam int SMCG_BIT_SFIFO2 = 1;
   localparam int SMCG_BIT_SFIFO0 = 0;

   // Gated module clock count and the one that survives standby
   localparam int SMCG_NUM_GATES = 14;
   localparam int SMCG_GATE_REALTIME = 1;

   // Processing state pin codes {hi, lo}
   localparam logic [1:0] SMCG_PS_RESET = 2'h3;
   localparam logic [1:0] SMCG_PS_SLEEP = 2'h2;
   localparam logic [1:0] SMCG_PS_STANDBY = 2'h1;
   localparam logic [1:0] SMCG_PS_NORMAL = 2'h0;

   typedef enum logic [1:0] {
      SMCG_MODE_RUN,
      SMCG_MODE_SLEEP,
      SMCG_MODE_STANDBY
   } smcg_mode_t;

   // APB request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } smcg_apb_req_t;

   // APB answer to the master
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } smcg_apb_rsp_t;

endpackage

// ==== design/smcg_clock_gate.sv ====
// Glitch-free clock gate for one peripheral module.
// Assumes stop is a level from pclk flops; output is pclk while enabled.
`timescale 1ns/1ps
`default_nettype none
module smcg_clock_gate (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic stop,
   output logic gclk,
   output logic running
);
   import smcg_pkg::*;

   typedef struct packed {
      logic en;
   } smcg_gate_state_t;

   smcg_gate_state_t st_ff;
   smcg_gate_state_t nxt_st;

   // Enable follows the stop request
   always_comb begin
      nxt_st = st_ff;
      nxt_st.en = ~stop;
   end

   // Falling edge capture: enable only moves while pclk is low
   always_ff @(negedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '{en: 1'b1};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign gclk = pclk & st_ff.en; // No truncated pulse
   assign running = st_ff.en;
endmodule
`default_nettype wire

// ==== design/smcg_state_pins.sv ====
// Processing state pin encoder.
// Assumes the mode comes from the pclk domain of the top.
`timescale 1ns/1ps
`default_nettype none
module smcg_state_pins (
   input wire logic pclk,
   input wire logic presetn,
   input wire smcg_pkg::smcg_mode_t mode,
   output logic proc_state_hi,
   output logic proc_state_lo
);
   import smcg_pkg::*;

   typedef struct packed {
      logic [1:0] pins;
   } smcg_pins_state_t;

   smcg_pins_state_t st_ff;
   smcg_pins_state_t nxt_st;

   // Mode to pin code
   always_comb begin
      nxt_st = st_ff;
      case (mode)
         SMCG_MODE_SLEEP: nxt_st.pins = SMCG_PS_SLEEP;
         SMCG_MODE_STANDBY: nxt_st.pins = SMCG_PS_STANDBY;
         default: nxt_st.pins = SMCG_PS_NORMAL;
      endcase
   end

   // Reset shows HH
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '{pins: SMCG_PS_RESET};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign proc_state_hi = st_ff.pins[1];
   assign proc_state_lo = st_ff.pins[0];
endmodule
`default_nettype wire

// ==== design/smcg_top.sv ====
// Standby control registers, halt mode sequencing and module clock gates.
// Assumes an APB master on pclk; halt_exec is a one-cycle pulse from the
// CPU and wake_req a level from the interrupt logic.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module smcg_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire smcg_pkg::smcg_apb_req_t apb_req,
   output smcg_pkg::smcg_apb_rsp_t apb_rsp,
   input wire logic halt_exec,
   input wire logic wake_req,
   output logic crystal_enable,
   output logic [13:0] module_clk,
   output logic proc_state_hi,
   output logic proc_state_lo
);
   import smcg_pkg::*;

   typedef struct packed {
      logic [7:0] primary;
      logic [7:0] second;
      logic [7:0] third;
      smcg_mode_t mode;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic xtal;
   } smcg_top_state_t;

   smcg_top_state_t st_ff;
   smcg_top_state_t nxt_st;
   logic [SMCG_NUM_GATES-1:0] stop_bits;
   logic [SMCG_NUM_GATES-1:0] gate_stop;
   logic [SMCG_NUM_GATES-1:0] gate_running;
   logic access;
   logic finish;
   logic wr_done;
   logic [7:0] wbyte;

   // Access phase seen, and the edge at which it completes
   assign access = apb_req.psel & apb_req.penable;
   assign finish = access & st_ff.pready;
   assign wr_done = finish & apb_req.pwrite & ~st_ff.pslverr;
   assign wbyte = apb_req.pwdata[7:0];

   // Software stop bits in gate order
   assign stop_bits[0] = st_ff.primary[SMCG_BIT_TIMER];
   assign stop_bits[1] = st_ff.primary[SMCG_BIT_REALTIME];
   assign stop_bits[2] = st_ff.second[SMCG_BIT_DEBUG];
   assign stop_bits[3] = st_ff.second[SMCG_BIT_BREAK];
   assign stop_bits[4] = st_ff.second[SMCG_BIT_DMA];
   assign stop_bits[5] = st_ff.second[SMCG_BIT_TLB];
   assign stop_bits[6] = st_ff.second[SMCG_BIT_CACHE];
   assign stop_bits[7] = st_ff.third[SMCG_BIT_USB];
   assign stop_bits[8] = st_ff.third[SMCG_BIT_COMPARE_TIMER];
   assign stop_bits[9] = st_ff.third[SMCG_BIT_PULSE_UNIT];
   assign stop_bits[10] = st_ff.third[SMCG_BIT_ADC];
   assign stop_bits[11] = st_ff.third[SMCG_BIT_IRDA];
   assign stop_bits[12] = st_ff.third[SMCG_BIT_SFIFO2];
   assign stop_bits[13] = st_ff.third[SMCG_BIT_SFIFO0];

   // One gate per module; standby halts all but the real-time unit,
   // which keeps its clock so it can wake the chip
   genvar g;
   generate
      for (g = 0; g < SMCG_NUM_GATES; g = g + 1) begin : gen_gate
         if (g == SMCG_GATE_REALTIME) begin : gen_rt
            assign gate_stop[g] = stop_bits[g];
         end else begin : gen_std
            assign gate_stop[g] = stop_bits[g] |
               (st_ff.mode == SMCG_MODE_STANDBY);
         end
         smcg_clock_gate u_gate (
            .pclk(pclk),
            .presetn(presetn),
            .stop(gate_stop[g]),
            .gclk(module_clk[g]),
            .running(gate_running[g])
         );
      end
   endgenerate

   // Register bus, mode sequencing and crystal control
   always_comb begin
      nxt_st = st_ff;

      // One wait state: answer registered in the first access cycle
      if (finish) begin
         nxt_st.pready = 1'b0;
         nxt_st.pslverr = 1'b0;
      end else if (access) begin
         nxt_st.pready = 1'b1;
         nxt_st.pslverr = 1'b0;
         nxt_st.prdata = 32'h0000_0000;
         if (apb_req.paddr == SMCG_OFS_PRIMARY) begin
            nxt_st.prdata[7:0] = st_ff.primary;
         end else if (apb_req.paddr == SMCG_OFS_SECOND) begin
            nxt_st.prdata[7:0] = st_ff.second;
         end else if (apb_req.paddr == SMCG_OFS_THIRD) begin
            nxt_st.prdata[7:0] = st_ff.third;
         end else if (apb_req.paddr == SMCG_OFS_STATUS) begin
            nxt_st.prdata[1:0] = {proc_state_hi, proc_state_lo};
            nxt_st.prdata[3:2] = st_ff.mode;
            nxt_st.prdata[4] = st_ff.xtal;
            nxt_st.prdata[18:5] = gate_running;
         end else begin
            nxt_st.pslverr = 1'b1; // Unmapped address
         end
         if (apb_req.pwrite && apb_req.paddr == SMCG_OFS_STATUS) begin
            nxt_st.pslverr = 1'b1; // Status is read-only
         end
      end

      // Write lands at the completing edge; reserved bits stay 0
      if (wr_done) begin
         if (apb_req.paddr == SMCG_OFS_PRIMARY) begin
            nxt_st.primary = wbyte & SMCG_WMASK_PRIMARY;
         end else if (apb_req.paddr == SMCG_OFS_SECOND) begin
            nxt_st.second = wbyte & SMCG_WMASK_SECOND;
         end else if (apb_req.paddr == SMCG_OFS_THIRD) begin
            nxt_st.third = wbyte & SMCG_WMASK_THIRD;
         end
      end

      // Halt picks its target from the standby select bit
      case (st_ff.mode)
         SMCG_MODE_RUN: begin
            if (halt_exec) begin
               if (st_ff.primary[SMCG_BIT_DEEP_STANDBY]) begin
                  nxt_st.mode = SMCG_MODE_STANDBY;
               end else begin
                  nxt_st.mode = SMCG_MODE_SLEEP;
               end
            end
         end
         SMCG_MODE_SLEEP: begin
            if (wake_req) begin
               nxt_st.mode = SMCG_MODE_RUN;
            end
         end
         SMCG_MODE_STANDBY: begin
            if (wake_req) begin
               nxt_st.mode = SMCG_MODE_RUN;
            end
         end
         default: begin
            nxt_st.mode = SMCG_MODE_RUN;
         end
      endcase

      // Crystal stops in standby unless told to keep running
      nxt_st.xtal = (nxt_st.mode != SMCG_MODE_STANDBY) |
         st_ff.primary[SMCG_BIT_CRYSTAL_KEEP];
   end

   // All fields but the crystal enable clear at reset, clocks therefore run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff.primary <= SMCG_RST_REG;
         st_ff.second <= SMCG_RST_REG;
         st_ff.third <= SMCG_RST_REG;
         st_ff.mode <= SMCG_MODE_RUN;
         st_ff.pready <= 1'b0;
         st_ff.pslverr <= 1'b0;
         st_ff.prdata <= 32'h0000_0000;
         st_ff.xtal <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Processing state pins follow the mode
   smcg_state_pins u_pins (
      .pclk(pclk),
      .presetn(presetn),
      .mode(st_ff.mode),
      .proc_state_hi(proc_state_hi),
      .proc_state_lo(proc_state_lo)
   );

   // One driver for the whole answer; error only shows with ready
   assign apb_rsp = '{pready: st_ff.pready,
      pslverr: st_ff.pslverr & st_ff.pready, prdata: st_ff.prdata};
   assign crystal_enable = st_ff.xtal;
endmodule
`default_nettype wire

// ==== sim/smcg_periph_model.sv ====
// Peripheral side model: one edge detector per gated module clock.
// Assumes clr is a pulse from the bench; ticked shows clocks seen since.
`timescale 1ns/1ps
`default_nettype none
module smcg_periph_model (
   input wire logic [13:0] module_clk,
   input wire logic clr,
   output logic [13:0] ticked
);
   // Modules hold no activity to quiet before a stop
   for (genvar i = 0; i < 14; i++) begin : g_mod
      always @(posedge module_clk[i] or posedge clr) begin
         if (clr) begin
            ticked[i] <= 1'b0;
         end else begin
            ticked[i] <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/smcg_top_properties.sv ====
// Checker for the standby registers, halt modes and module clock gates.
// Sees only top ports; shadows the three registers from APB writes.
`timescale 1ns/1ps
`default_nettype none
module smcg_top_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire smcg_pkg::smcg_apb_req_t apb_req,
   input wire smcg_pkg::smcg_apb_rsp_t apb_rsp,
   input wire logic halt_exec,
   input wire logic wake_req,
   input wire logic crystal_enable,
   input wire logic [13:0] module_clk,
   input wire logic proc_state_hi,
   input wire logic proc_state_lo
);
   import smcg_pkg::*;
   logic [7:0] p_ff, s_ff, t_ff, wd, rd_exp;
   logic [1:0] ps;
   logic [13:0] stop;
   logic done, bad;
   // Shadows move only where a write completes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p_ff <= 8'h00;
         s_ff <= 8'h00;
         t_ff <= 8'h00;
      end else if (done && apb_req.pwrite && !bad) begin
         case (apb_req.paddr)
            SMCG_OFS_PRIMARY: p_ff <= wd & SMCG_WMASK_PRIMARY;
            SMCG_OFS_SECOND: s_ff <= wd & SMCG_WMASK_SECOND;
            SMCG_OFS_THIRD: t_ff <= wd & SMCG_WMASK_THIRD;
            default: ;
         endcase
      end
   end
   // Decode of the transfer and gate order of module_clk
   assign wd = apb_req.pwdata[7:0];
   assign ps = {proc_state_hi, proc_state_lo};
   assign done = apb_req.psel && apb_req.penable && apb_rsp.pready;
   assign bad = !(apb_req.paddr inside {SMCG_OFS_PRIMARY, SMCG_OFS_SECOND,
      SMCG_OFS_THIRD} || (apb_req.paddr == SMCG_OFS_STATUS &&
      !apb_req.pwrite));
   assign rd_exp = (apb_req.paddr == SMCG_OFS_PRIMARY) ? p_ff :
      (apb_req.paddr == SMCG_OFS_SECOND) ? s_ff : t_ff;
   assign stop = {t_ff[0], t_ff[1], t_ff[2], t_ff[3], t_ff[4], t_ff[5],
      t_ff[7], s_ff[2], s_ff[3], s_ff[5], s_ff[6], s_ff[7], p_ff[1], p_ff[2]};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_READY_WAIT: assert property (
      apb_req.psel && $rose(apb_req.penable) |=> apb_rsp.pready)
      else $error("pready late after access cycle");
   AST_SLVERR: assert property (
      done |-> apb_rsp.pslverr == bad)
      else $error("pslverr wrong for address");
   AST_READBACK: assert property (
      done && !apb_req.pwrite && !bad && apb_req.paddr != SMCG_OFS_STATUS
      |-> apb_rsp.prdata == {24'h0, rd_exp})
      else $error("register read data wrong");
   AST_HALT_SLEEP: assert property (
      halt_exec && ps == SMCG_PS_NORMAL && !p_ff[7]
      |-> ##[1:2] ps == SMCG_PS_SLEEP) else $error("sleep not entered");
   AST_HALT_STANDBY: assert property (
      halt_exec && ps == SMCG_PS_NORMAL && p_ff[7]
      |-> ##[1:2] ps == SMCG_PS_STANDBY) else $error("standby not entered");
   AST_CRYSTAL: assert property (
      ps == SMCG_PS_STANDBY && !wake_req && !$past(wake_req)
      && !$past(wake_req, 2) |-> crystal_enable == p_ff[4])
      else $error("crystal enable wrong in standby");
   // Gates checked a falling edge after the stop bit moved
   AST_GATE_PRI: assert property (
      @(negedge pclk) disable iff (!presetn)
      ps == SMCG_PS_NORMAL |-> module_clk[1:0] == ~$past(stop[1:0]))
      else $error("primary module clock gate wrong");
   AST_GATE_SEC_A: assert property (
      @(negedge pclk) disable iff (!presetn)
      ps == SMCG_PS_NORMAL |-> module_clk[4:2] == ~$past(stop[4:2]))
      else $error("second module clock gate wrong");
   AST_GATE_SEC_B: assert property (
      @(negedge pclk) disable iff (!presetn)
      ps == SMCG_PS_NORMAL |-> module_clk[6:5] == ~$past(stop[6:5]))
      else $error("second module clock gate wrong");
   AST_GATE_THI_A: assert property (
      @(negedge pclk) disable iff (!presetn)
      ps == SMCG_PS_NORMAL |-> module_clk[9:7] == ~$past(stop[9:7]))
      else $error("third module clock gate wrong");
   AST_GATE_THI_B: assert property (
      @(negedge pclk) disable iff (!presetn)
      ps == SMCG_PS_NORMAL |-> module_clk[13:10] == ~$past(stop[13:10]))
      else $error("third module clock gate wrong");
   AST_STANDBY_GATES: assert property (
      @(negedge pclk) disable iff (!presetn) ps == SMCG_PS_STANDBY
      |-> module_clk == {12'h000, !$past(p_ff[1]), 1'b0})
      else $error("module clock running in standby");
   COV_STANDBY: cover property (ps == SMCG_PS_STANDBY);
   COV_SLEEP: cover property (ps == SMCG_PS_SLEEP);
   COV_REFUSED: cover property (done && bad);
endmodule
bind smcg_top smcg_top_properties smcg_top_properties_inst (.pclk, .presetn,
   .apb_req, .apb_rsp, .halt_exec, .wake_req, .crystal_enable, .module_clk,
   .proc_state_hi, .proc_state_lo);
`default_nettype wire

// ==== sim/smcg_top_test.sv ====
// Self-checking bench for the standby registers and module clock gates.
// Drives APB, halt and wake; the peripheral model reports live clocks.
`timescale 1ns/1ps
`default_nettype none
module smcg_top_test;
   import smcg_pkg::*;
   logic pclk, presetn, halt_exec, wake_req, clr, crystal_enable, err;
   logic proc_state_hi, proc_state_lo;
   logic [13:0] module_clk, ticked;
   logic [31:0] rd;
   smcg_apb_req_t req;
   smcg_apb_rsp_t rsp;
   int err_count, tests_run;
   logic [7:0] pat [4][3];
   logic [7:0] msk [3];
   logic [13:0] run_exp [4];
   smcg_top smcg_top_inst (.pclk, .presetn, .apb_req(req), .apb_rsp(rsp),
      .halt_exec, .wake_req, .crystal_enable, .module_clk, .proc_state_hi,
      .proc_state_lo);
   smcg_periph_model smcg_periph_model_inst (.module_clk, .clr, .ticked);
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; waits for pready, bounded
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
      @(posedge pclk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 16);
      chk("pready", 1, rsp.pready);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task rd_chk(input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk("readback", {24'h0, exp}, rd);
   endtask
   // Clear the model, then see which module clocks tick
   task gates(input logic [13:0] exp);
      repeat (3) @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("gates", {18'h0, exp}, {18'h0, ticked});
   endtask
   // Halt, check pins, crystal, gates and status, then wake
   task halt(input logic [7:0] pr, input logic [1:0] pin,
      input logic [13:0] r);
      apb(1'b1, SMCG_OFS_PRIMARY, pr);
      @(posedge pclk);
      halt_exec <= 1'b1;
      @(posedge pclk);
      halt_exec <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("pins", {30'h0, pin},
         {30'h0, proc_state_hi, proc_state_lo});
      chk("crystal", {31'h0, !pr[7] || pr[4]},
         {31'h0, crystal_enable});
      gates(r);
      // Status: running gates, crystal, mode code, pins
      apb(1'b0, SMCG_OFS_STATUS, 8'h00);
      chk("status", {13'h0, r, (!pr[7] || pr[4]), (pr[7] ? 2'h2 : 2'h1), pin},
         rd);
      wake_req <= 1'b1;
      @(posedge pclk);
      wake_req <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("pins", 0, {30'h0, proc_state_hi, proc_state_lo});
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #100us;
      err_count++;
      conclude();
   end
   initial begin
      presetn = 1'b0;
      req = '0;
      {halt_exec, wake_req, clr} = 3'h0;
      err_count = 0;
      tests_run = 0;
      msk = '{SMCG_WMASK_PRIMARY, SMCG_WMASK_SECOND, SMCG_WMASK_THIRD};
      // All stops, even gates, odd gates, none
      pat = '{'{8'hff, 8'hff, 8'hff}, '{8'h04, 8'ha4, 8'h2a},
         '{8'h02, 8'h48, 8'h95}, '{8'h00, 8'h00, 8'h00}};
      run_exp = '{14'h0000, 14'h2aaa, 14'h1555, 14'h3fff};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int j = 0; j < 3; j++) begin
         rd_chk(12'(4 * j), 8'h00);
      end
      gates(14'h3fff);
      apb(1'b0, SMCG_OFS_STATUS, 8'h00);
      chk("status", 32'h0007_fff0, rd);
      for (int i = 0; i < 4; i++) begin
         for (int j = 0; j < 3; j++) begin
            apb(1'b1, 12'(4 * j), pat[i][j]);
            rd_chk(12'(4 * j), pat[i][j] & msk[j]);
         end
         gates(run_exp[i]);
      end
      apb(1'b0, 12'h010, 8'h00);
      chk("unmapped", 1, err);
      apb(1'b1, SMCG_OFS_STATUS, 8'hff);
      chk("status write", 1, err);
      halt(8'h00, SMCG_PS_SLEEP, 14'h3fff);
      halt(8'h90, SMCG_PS_STANDBY, 14'h0002);
      halt(8'h82, SMCG_PS_STANDBY, 14'h0000);
      // Reset in mid-run restores every stopped clock
      apb(1'b1, SMCG_OFS_THIRD, 8'hff);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(SMCG_OFS_PRIMARY, 8'h00);
      rd_chk(SMCG_OFS_THIRD, 8'h00);
      gates(14'h3fff);
      conclude();
   end
endmodule
`default_nettype wire
